/* File: tbsr_fifo2.sv */
// Two-entry buffer with valid and ready on both sides.
`timescale 1ns/10ps
`default_nettype none
module tbsr_fifo2
   import tbsr_pkg::*;
#(
   parameter int unsigned W = TBSR_WORD_W
)
(
   input  wire logic         ref_clk_in,  // core clock
   input  wire logic         rst_n_in,    // synchronous reset, active low
   input  wire logic         in_valid_in, // word offered
   output logic              in_ready_out,// room for a word
   input  wire logic [W-1:0] in_data_in,  // word in
   output logic              out_valid_out,// word available
   input  wire logic         out_ready_in, // receiver takes word
   output logic      [W-1:0] out_data_out, // word out
   output logic              empty_out     // no word held
);
   // Valid is kept as its own flop so the reader sees it straight from a register.
   typedef struct packed {
      logic [W-1:0] e0;
      logic [W-1:0] e1;
      logic [1:0]   cnt;
      logic         v;
   } tbsr_fifo_state_s;

   tbsr_fifo_state_s st_q;
   tbsr_fifo_state_s st_d;
   logic             push;
   logic             pop;

   always_comb
   begin
      st_d = st_q;
      push = in_valid_in && (st_q.cnt != 2'h2);
      pop  = out_ready_in && (st_q.cnt != 2'h0);
      if (pop)
      begin
         st_d.e0 = st_q.e1;
      end
      if (push)
      begin
         if (st_d.cnt - {1'b0, pop} == 2'h0)
         begin
            st_d.e0 = in_data_in;
         end
         else
         begin
            st_d.e1 = in_data_in;
         end
      end
      st_d.cnt = st_q.cnt + {1'b0, push} - {1'b0, pop};
      if (!rst_n_in)
      begin
         st_d.cnt = 2'h0;
      end
      st_d.v = (st_d.cnt != 2'h0);
   end

   always_ff @(posedge ref_clk_in)
   begin
      st_q <= st_d;
   end

   assign in_ready_out   = st_q.cnt != 2'h2;
   assign out_valid_out  = st_q.v;
   assign out_data_out   = st_q.e0;
   assign empty_out      = st_q.cnt == 2'h0;
endmodule // tbsr_fifo2
`default_nettype wire

/* File: tbsr_mem.sv */
// Trace line store with registered read data and no reset.
`timescale 1ns/10ps
`default_nettype none
module tbsr_mem
   import tbsr_pkg::*;
#(
   parameter int unsigned DEPTH = TBSR_DEPTH,
   parameter int unsigned AW    = TBSR_PTR_W,
   parameter int unsigned W     = TBSR_LINE_W
)
(
   input  wire logic          ref_clk_in,   // core clock
   input  wire logic          we_in,        // write strobe
   input  wire logic [AW-1:0] waddr_in,     // write line
   input  wire logic [W-1:0]  wdata_in,     // write data
   input  wire logic [AW-1:0] raddr_in,     // read line
   output logic      [W-1:0]  rdata_out     // read data, one cycle later
);
   logic [W-1:0] mem_q [DEPTH];

   // Contents survive system reset so a pre-reset session stays readable.
   always_ff @(posedge ref_clk_in)
   begin
      if (we_in)
      begin
         mem_q[waddr_in] <= wdata_in;
      end
      rdata_out <= mem_q[raddr_in];
   end
endmodule // tbsr_mem
`default_nettype wire

/* File: tbsr_pkg.sv */
// Package of constants and types for the trace buffer timestamp_enable and readout block.
// Functional notes
// - Mid trigger marks line, closes it, forces base.
// - PC arriving with trigger stays on marked line.
// - Info byte holds three-bit payload byte count.
// - Base flag marks lowest byte of full PC starting in bytes 0 to 3.
// - Compressed PC mode records no timestamps or events.
// - Stamping stores 16-bit counter with every entry.
// - Timestamp_enable equals core cycles since last entry minus one.
// - First entry of a session stamps zero.
// - Counter at all ones forces entry with overflow flag.
// - Comparator D match forces entry with comparator flag.
// - Comparator D reaches sequencer only when selected.
// - Comparator forced entry stores the previous PC.
// - Readout only disarmed and traced; arming locks buffer.
// - Aligned word write unlocks; aligned word reads only.
// - Refused reads return 0xEE, pointer unchanged.
// - Profiling enabled blocks valid readout data.
// - Oldest first; line count not decremented by reads.
// - Pointer starts at oldest; aligned write re-points it.
// - After last line the pointer wraps to line 0.
// - Low word of each line first, every byte returned.
// - Reset keeps buffer contents and line count.
// - Reset clears readout pointer; write restores it.
package tbsr_pkg;
   localparam int unsigned TBSR_DEPTH    = 64;
   localparam int unsigned TBSR_PTR_W    = 6;
   localparam int unsigned TBSR_CNT_W    = 7;
   localparam int unsigned TBSR_LINE_W   = 64;
   localparam int unsigned TBSR_WORD_W   = 32;
   localparam int unsigned TBSR_TS_W     = 16;
   localparam int unsigned TBSR_PC_W     = 24;
   localparam int unsigned TBSR_PAYLOAD  = 7;
   localparam int unsigned TBSR_TS_LSB   = 48;
   localparam int unsigned TBSR_TSI_LSB  = 24;
   localparam int unsigned TBSR_INFO_LSB = 56;
   // Timestamp_enable info byte bit positions.
   localparam int unsigned TSI_CTI  = 3;
   localparam int unsigned TSI_PC   = 2;
   localparam int unsigned TSI_TAG  = 1;
   localparam int unsigned TSI_TIMESTAMP_OVERFLOW_FLAG = 0;
   localparam logic [15:0] TS_ALL_ONES = 16'hFFFF;
   localparam logic [15:0] TS_ZERO     = 16'h0000;
   localparam logic [31:0] RD_REFUSED  = 32'h0000_00EE;
   localparam logic [2:0]  PAYLOAD_ENTRY_COUNT_ZERO   = 3'h0;
   localparam logic [2:0]  PAYLOAD_ENTRY_COUNT_ONE    = 3'h1;
   localparam logic [2:0]  BASE_BYTES  = 3'h3;
   localparam logic [2:0]  COMP_LIMIT  = 3'h3;
   localparam logic [2:0]  PAYLOAD_ENTRY_COUNT_MAX    = 3'h7;
   localparam logic [6:0]  CNT_FULL    = 7'h40;
   localparam logic [6:0]  CNT_ONE     = 7'h01;
   localparam logic [5:0]  PTR_ONE     = 6'h01;

   typedef enum logic [1:0] {
      TBSR_NORMAL  = 2'b00,
      TBSR_LOOP    = 2'b01,
      TBSR_DETAIL  = 2'b10,
      TBSR_PURE_PC = 2'b11
   } tbsr_mode_e;

   typedef struct packed {
      logic       armed;
      logic       trigger;
      logic       mid_align;
      logic       trace_source_select;
      logic       profiling_enable;
      logic       timestamp_enable;
      logic       comparator_timestamp_enable_enable;
      logic       comp_d_seq_select;
      tbsr_mode_e mode;
   } tbsr_ctrl_s;

   typedef struct packed {
      logic        valid;
      logic [23:0] pc;
   } tbsr_pc_s;

   typedef struct packed {
      logic        req;
      logic [63:0] data;
   } tbsr_entry_s;

   typedef struct packed {
      logic rd;
      logic wr;
      logic aligned;
      logic word;
   } tbsr_port_s;

   typedef struct packed {
      logic        armed_prev;
      logic        locked;
      logic [15:0] ts;
      logic        first;
      logic [23:0] prev_pc;
      logic [23:0] last_pc;
      logic        need_base;
      logic [55:0] line;
      logic [6:0]  nb;
      logic [2:0]  payload_entry_count;
      logic [5:0]  wr_ptr;
      logic [6:0]  line_cnt;
      logic [5:0]  rd_ptr;
      logic [6:0]  rd_num;
      logic        rd_hi;
      logic        pend;
      logic        pend_hi;
      logic        rdy;
      logic        comp_seq;
   } tbsr_state_s;
endpackage : tbsr_pkg

/* File: tbsr_reader_model.sv */
// Reader model that takes read words from the trace buffer port after a chosen stall.
`timescale 1ns/10ps
`default_nettype none
module tbsr_reader_model
(
   input  wire logic        ref_clk_in, // core clock
   input  wire logic        rst_n_in,   // synchronous reset, active low
   input  wire logic [3:0]  stall_in,   // cycles to hold off each word
   input  wire logic        valid_in,   // word offered
   input  wire logic [31:0] data_in,    // word offered
   output logic             take_out,   // reader takes the word
   output logic [31:0]      word_out,   // last word taken
   output logic [15:0]      count_out   // words taken so far
);
   logic [3:0] wait_q;
   // Each word is taken whole at the edge where ready meets valid.
   always_ff @(posedge ref_clk_in)
   begin
      if (!rst_n_in)
      begin
         take_out  <= 1'b0;
         wait_q    <= 4'h0;
         count_out <= 16'h0000;
      end
      else if (valid_in && take_out)
      begin
         word_out  <= data_in;
         count_out <= count_out + 16'h0001;
         take_out  <= 1'b0;
         wait_q    <= 4'h0;
      end
      else if (valid_in && (wait_q >= stall_in))
         take_out <= 1'b1;
      else if (valid_in)
         wait_q <= wait_q + 4'h1;
   end
endmodule // tbsr_reader_model
`default_nettype wire

/* File: tbsr_top.sv */
// Trace line assembly, timestamping and locked FIFO readout of the trace buffer.
`timescale 1ns/10ps
`default_nettype none
module tbsr_top
   import tbsr_pkg::*;
(
   input  wire logic        ref_clk_in,        // core clock, 20 MHz
   input  wire logic        rst_n_in,          // system reset, active low
   input  wire tbsr_ctrl_s  ctrl_in,           // debug unit control bits
   input  wire logic        comp_d_match_in,   // comparator D hit
   input  wire tbsr_pc_s    pc_in,             // executed PC for compressed mode
   input  wire logic        pc_full_in,        // capture logic forces a full entry
   input  wire tbsr_entry_s entry_in,          // stamped-mode entry from capture logic
   input  wire tbsr_port_s  port_in,           // trace buffer port access
   output logic             rd_ready_out,      // port can take a read
   output logic             rd_valid_out,      // read word available
   input  wire logic        rd_ready_in,       // reader takes the word
   output logic [31:0]      rd_data_out,       // read word
   output logic [6:0]       line_count_out,    // valid line count
   output logic             locked_out,        // buffer locked against reading
   output logic             comp_d_seq_out     // comparator D toward sequencer
);
   tbsr_state_s st_q;
   tbsr_state_s st_d;
   logic        wr_now;
   logic [63:0] wr_data;
   logic [63:0] mem_rdata;
   logic [5:0]  oldest;
   logic        stamping;
   logic        force_ovf;
   logic        force_cmp;
   logic        rd_ok;
   logic        rd_acc;
   logic        refused;
   logic        push_v;
   logic [31:0] push_d;
   logic        f_empty;
   logic        close;
   logic        compressed;
   logic [7:0]  info;
   logic [7:0]  tsinf;
   logic        arm_rise;
   logic        arm_fall;

   always_comb
   begin
      st_d     = st_q;
      wr_now   = 1'b0;
      wr_data  = '0;
      close    = 1'b0;
      info     = '0;
      tsinf    = '0;
      arm_rise = ctrl_in.armed && !st_q.armed_prev;
      arm_fall = !ctrl_in.armed && st_q.armed_prev;
      oldest   = (st_q.line_cnt == CNT_FULL) ? st_q.wr_ptr : '0;
      st_d.armed_prev = ctrl_in.armed;
      st_d.comp_seq = comp_d_match_in && ctrl_in.comp_d_seq_select;
      stamping = ctrl_in.armed && ctrl_in.timestamp_enable
                 && (ctrl_in.mode != TBSR_PURE_PC);
      force_ovf = stamping && (st_q.ts == TS_ALL_ONES);
      force_cmp = stamping && ctrl_in.comparator_timestamp_enable_enable
                  && comp_d_match_in;
      compressed = !pc_full_in && !st_q.need_base && (st_q.payload_entry_count <= COMP_LIMIT)
                   && (pc_in.pc[23:8] == st_q.last_pc[23:8]);
      if (arm_rise)
      begin
         // A new session starts an empty buffer; the count is kept until then.
         st_d.ts        = TS_ZERO;
         st_d.first     = 1'b1;
         st_d.need_base = 1'b1;
         st_d.wr_ptr    = '0;
         st_d.line_cnt  = '0;
         st_d.payload_entry_count      = PAYLOAD_ENTRY_COUNT_ZERO;
         st_d.nb        = '0;
         st_d.line      = '0;
      end
      else if (ctrl_in.armed && ctrl_in.mode == TBSR_PURE_PC)
      begin
         if (pc_in.valid)
         begin
            st_d.last_pc = pc_in.pc;
            if (compressed)
            begin
               st_d.line[8*st_q.payload_entry_count +: 8] = pc_in.pc[7:0];
               st_d.payload_entry_count = st_q.payload_entry_count + PAYLOAD_ENTRY_COUNT_ONE;
            end
            else
            begin
               for (int k = 0; k < 3; k++)
               begin
                  if (int'(st_q.payload_entry_count) + k < TBSR_PAYLOAD)
                  begin
                     st_d.line[8*(int'(st_q.payload_entry_count)+k) +: 8] = pc_in.pc[8*k +: 8];
                  end
               end
               st_d.nb[st_q.payload_entry_count] = 1'b1;
               st_d.payload_entry_count = st_q.payload_entry_count + BASE_BYTES;
               st_d.need_base = 1'b0;
               close = (st_q.payload_entry_count + BASE_BYTES) > COMP_LIMIT;
            end
         end
         // A PC taken with the trigger stays on the marked line.
         if (ctrl_in.trigger && ctrl_in.mid_align)
         begin
            close          = 1'b1;
            info[7]        = 1'b1;
            st_d.need_base = 1'b1;
         end
      end
      else if (arm_fall && st_q.payload_entry_count != PAYLOAD_ENTRY_COUNT_ZERO)
      begin
         close = 1'b1;
      end
      else if (stamping)
      begin
         st_d.ts = st_q.ts + 16'h0001;
         if (pc_in.valid)
         begin
            st_d.prev_pc = pc_in.pc;
         end
         if (entry_in.req || force_ovf || force_cmp)
         begin
            tsinf[TSI_TAG]  = 1'b1;
            tsinf[TSI_TIMESTAMP_OVERFLOW_FLAG] = force_ovf;
            tsinf[TSI_CTI]  = force_cmp;
            tsinf[TSI_PC]   = 1'b1;
            wr_now  = 1'b1;
            wr_data = entry_in.req ? entry_in.data : {40'h0, st_q.prev_pc};
            wr_data[TBSR_TSI_LSB +: 8] = tsinf;
            wr_data[TBSR_TS_LSB +: 16] = st_q.first ? TS_ZERO : st_q.ts;
            st_d.ts    = TS_ZERO;
            st_d.first = 1'b0;
         end
      end
      if (close)
      begin
         info[6:4] = (st_d.payload_entry_count > PAYLOAD_ENTRY_COUNT_MAX) ? PAYLOAD_ENTRY_COUNT_MAX : st_d.payload_entry_count;
         info[3:0] = st_d.nb[3:0];
         wr_now  = 1'b1;
         wr_data = {info, st_d.line};
         st_d.payload_entry_count = PAYLOAD_ENTRY_COUNT_ZERO;
         st_d.nb   = '0;
         st_d.line = '0;
      end
      if (wr_now)
      begin
         st_d.wr_ptr = st_q.wr_ptr + PTR_ONE;
         if (st_q.line_cnt != CNT_FULL)
         begin
            st_d.line_cnt = st_q.line_cnt + CNT_ONE;
         end
      end

      // Readout side.
      if (ctrl_in.armed)
      begin
         st_d.locked = 1'b1;
      end
      rd_ok = !ctrl_in.armed && !st_q.locked && ctrl_in.trace_source_select
              && !ctrl_in.profiling_enable
              && port_in.aligned && port_in.word;
      rd_acc  = port_in.rd && st_q.rdy;
      refused = rd_acc && !rd_ok;
      st_d.pend    = rd_acc && rd_ok;
      st_d.pend_hi = st_q.rd_hi;
      if (rd_acc && rd_ok)
      begin
         st_d.rd_hi = !st_q.rd_hi;
         if (st_q.rd_hi)
         begin
            if (st_q.rd_num + CNT_ONE >= st_q.line_cnt)
            begin
               st_d.rd_ptr = '0;
               st_d.rd_num = '0;
            end
            else
            begin
               st_d.rd_ptr = st_q.rd_ptr + PTR_ONE;
               st_d.rd_num = st_q.rd_num + CNT_ONE;
            end
         end
      end
      if (port_in.wr && port_in.aligned && port_in.word && !ctrl_in.armed)
      begin
         st_d.locked = 1'b0;
         st_d.rd_ptr = oldest;
         st_d.rd_num = '0;
         st_d.rd_hi  = 1'b0;
      end
      if (arm_fall)
      begin
         st_d.rd_ptr = '0;
         st_d.rd_num = '0;
         st_d.rd_hi  = 1'b0;
      end
      // Reads are taken only with the buffer drained, so no answer is ever dropped.
      st_d.rdy = !rd_acc && !st_d.pend && !st_q.pend && f_empty;
      if (!rst_n_in)
      begin
         // Line count and write pointer survive so the old session stays readable.
         st_d.armed_prev = 1'b0;
         st_d.locked     = 1'b1;
         st_d.ts         = TS_ZERO;
         st_d.first      = 1'b1;
         st_d.need_base  = 1'b1;
         st_d.payload_entry_count       = PAYLOAD_ENTRY_COUNT_ZERO;
         st_d.nb         = '0;
         st_d.rd_ptr     = '0;
         st_d.rd_num     = '0;
         st_d.rd_hi      = 1'b0;
         st_d.pend       = 1'b0;
         st_d.rdy        = 1'b0;
         st_d.comp_seq   = 1'b0;
         st_d.line_cnt   = st_q.line_cnt;
      end
      push_v = st_q.pend || refused;
      push_d = refused ? RD_REFUSED
             : (st_q.pend_hi ? mem_rdata[63:32] : mem_rdata[31:0]);
   end

   always_ff @(posedge ref_clk_in)
   begin
      st_q <= st_d;
   end

   tbsr_mem u_mem (
      .ref_clk_in (ref_clk_in),
      .we_in      (wr_now),
      .waddr_in   (st_q.wr_ptr),
      .wdata_in   (wr_data),
      .raddr_in   (st_q.rd_ptr),
      .rdata_out  (mem_rdata)
   );

   tbsr_fifo2 #(.W(TBSR_WORD_W)) u_fifo (
      .ref_clk_in     (ref_clk_in),
      .rst_n_in       (rst_n_in),
      .in_valid_in    (push_v),
      .in_ready_out   (),
      .in_data_in     (push_d),
      .out_valid_out  (rd_valid_out),
      .out_ready_in   (rd_ready_in),
      .out_data_out   (rd_data_out),
      .empty_out      (f_empty)
   );

   assign rd_ready_out   = st_q.rdy;
   assign line_count_out = st_q.line_cnt;
   assign locked_out     = st_q.locked;
   assign comp_d_seq_out = st_q.comp_seq;

   sequence s_refused;
      rd_acc && !rd_ok;
   endsequence
   sequence s_ptr_kept;
      ##1 (st_q.rd_ptr == $past(st_q.rd_ptr)) && (st_q.rd_hi == $past(st_q.rd_hi));
   endsequence
   sequence s_pure_run;
      ctrl_in.armed && st_q.armed_prev && (ctrl_in.mode == TBSR_PURE_PC);
   endsequence

   refused_word_a : assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
      s_refused |-> push_v && push_d == RD_REFUSED)
      else $error("refused read did not answer 0xEE");
   refused_ptr_a : assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
      s_refused ##0 (!port_in.wr && !arm_fall) |-> s_ptr_kept)
      else $error("refused read moved the pointer");
   arm_lock_a : assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
      ctrl_in.armed |=> st_q.locked)
      else $error("armed buffer not locked");
   reset_count_a : assert property (@(posedge ref_clk_in)
      !rst_n_in && st_q.line_cnt <= CNT_FULL
         |=> st_q.line_cnt == $past(st_q.line_cnt) && st_q.rd_ptr == '0)
      else $error("reset lost count or kept pointer");
   timestamp_enable_ovf_a : assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
      force_ovf && !st_q.first && st_q.armed_prev |-> wr_now && wr_data[TBSR_TSI_LSB + TSI_TIMESTAMP_OVERFLOW_FLAG]
         && wr_data[TBSR_TS_LSB +: 16] == TS_ALL_ONES)
      else $error("overflow entry missing");
   ts_restart_a : assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
      wr_now && stamping |=> st_q.ts == TS_ZERO)
      else $error("counter not restarted");
   pure_nostamp_a : assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
      s_pure_run |=> st_q.ts == $past(st_q.ts))
      else $error("timestamp_enable in compressed mode");
   mid_mark_a : assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
      s_pure_run ##0 (ctrl_in.trigger && ctrl_in.mid_align)
         |-> wr_now && wr_data[TBSR_LINE_W - 1])
      else $error("mid trigger line not closed and marked");
   repoint_a : assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
      port_in.wr && port_in.aligned && port_in.word && !ctrl_in.armed
         && !st_q.armed_prev |=> st_q.rd_ptr == $past(oldest) && !st_q.locked)
      else $error("write did not re-point");
   cmp_flag_a : assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
      force_cmp && st_q.armed_prev && ctrl_in.mode != TBSR_PURE_PC |-> wr_now
         && wr_data[TBSR_TSI_LSB + TSI_CTI])
      else $error("comparator entry missing flag");
   seq_gate_a : assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
      comp_d_match_in && !ctrl_in.comp_d_seq_select |=> !comp_d_seq_out)
      else $error("comparator reached sequencer unselected");
endmodule // tbsr_top
`default_nettype wire

/* File: trace_buffer_timestamp_enable_readout_test.sv */
// Self-checking bench for trace stamping and locked trace buffer readout.
`timescale 1ns/10ps
`default_nettype none
module trace_buffer_timestamp_enable_readout_test;
   import tbsr_pkg::*;
   logic        ref_clk_in = 1'b0;
   logic        rst_n_in   = 1'b0;
   tbsr_ctrl_s  ctrl;
   logic        comp_d;
   tbsr_pc_s    pc;
   tbsr_entry_s entry;
   tbsr_port_s  port;
   logic        rd_ready, rd_valid, take, locked, comp_seq, seen;
   logic [31:0] rd_data, word, w;
   logic [6:0]  line_count;
   logic [3:0]  stall;
   logic [15:0] got_n;
   int          fail_count = 0;
   int          checks = 0;

   initial forever #25 ref_clk_in = ~ref_clk_in;

   tbsr_top i_dut (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .ctrl_in(ctrl),
      .comp_d_match_in(comp_d), .pc_in(pc), .pc_full_in(1'b0), .entry_in(entry),
      .port_in(port), .rd_ready_out(rd_ready), .rd_valid_out(rd_valid),
      .rd_ready_in(take), .rd_data_out(rd_data), .line_count_out(line_count),
      .locked_out(locked), .comp_d_seq_out(comp_seq));

   tbsr_reader_model i_reader (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
      .stall_in(stall), .valid_in(rd_valid), .data_in(rd_data), .take_out(take),
      .word_out(word), .count_out(got_n));

   task automatic give_verdict;
      $display("checks=%0d fail_count=%0d", checks, fail_count);
      if (fail_count == 0 && checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic bail;
      fail_count++;
      give_verdict();
   endtask

   task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp,
                           input logic [31:0] mask);
      checks++;
      if ((got & mask) !== (exp & mask))
      begin
         fail_count++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got & mask, exp & mask);
      end
   endtask

   task automatic cmp_bit(input logic got, input logic exp);
      checks++;
      if (got !== exp)
      begin
         fail_count++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // A read is offered only while the port is ready and the buffer has drained.
   task automatic port_read(input logic al, input logic wd, output logic [31:0] data);
      logic [15:0] n0;
      int          i;
      i = 0;
      @(negedge ref_clk_in);
      while (rd_ready !== 1'b1)
      begin
         i++;
         if (i > 50) bail();
         @(negedge ref_clk_in);
      end
      n0 = got_n;
      port = '{rd: 1'b1, wr: 1'b0, aligned: al, word: wd};
      @(negedge ref_clk_in);
      port = '0;
      i = 0;
      while (got_n === n0)
      begin
         i++;
         if (i > 50) bail();
         @(negedge ref_clk_in);
      end
      data = word;
   endtask

   task automatic port_write;
      @(negedge ref_clk_in);
      port = '{rd: 1'b0, wr: 1'b1, aligned: 1'b1, word: 1'b1};
      @(negedge ref_clk_in);
      port = '0;
   endtask

   task automatic pulse_entry(input logic [63:0] d, input logic cmp);
      @(negedge ref_clk_in);
      entry  = '{req: ~cmp, data: d};
      comp_d = cmp;
      @(negedge ref_clk_in);
      entry.req = 1'b0;
      comp_d    = 1'b0;
   endtask

   task automatic pc_step(input logic [23:0] a, input logic trg);
      @(negedge ref_clk_in);
      pc = '{valid: 1'b1, pc: a};
      ctrl.trigger = trg;
      @(negedge ref_clk_in);
      pc.valid     = 1'b0;
      ctrl.trigger = 1'b0;
   endtask

   task automatic check_line(input logic [31:0] lo, input logic [31:0] hi,
                             input logic [31:0] lo_m, input logic [31:0] hi_m);
      port_read(1'b1, 1'b1, w);
      cmp_word(w, lo, lo_m);
      port_read(1'b1, 1'b1, w);
      cmp_word(w, hi, hi_m);
   endtask

   initial
   begin
      ctrl = '0;
      ctrl.trace_source_select = 1'b1;
      ctrl.mode = TBSR_NORMAL;
      {comp_d, seen} = 2'b00;
      pc = '0;
      entry = '0;
      port = '0;
      stall = 4'h0;
      repeat (2) @(negedge ref_clk_in);
      rst_n_in = 1'b1;
      @(negedge ref_clk_in);
      {ctrl.armed, ctrl.timestamp_enable, ctrl.comparator_timestamp_enable_enable} = 3'b111;
      repeat (3) @(negedge ref_clk_in);
      pulse_entry(64'h0000_1234_0056_789A, 1'b0);
      repeat (3) @(negedge ref_clk_in);
      pulse_entry(64'h0000_4321_00AB_CDEF, 1'b0);
      pc = '{valid: 1'b1, pc: 24'h12_3456};
      @(negedge ref_clk_in);
      pc.valid = 1'b0;
      repeat (7) @(negedge ref_clk_in);
      pulse_entry(64'h0, 1'b1);
      repeat (2)
      begin
         cmp_bit(comp_seq, 1'b0);
         @(negedge ref_clk_in);
      end
      port_read(1'b1, 1'b1, w);
      cmp_word(w, RD_REFUSED, 32'hFFFF_FFFF);
      repeat (65540) @(negedge ref_clk_in);
      ctrl.armed = 1'b0;
      @(negedge ref_clk_in);
      cmp_word({25'h0, line_count}, 32'h0000_0004, 32'hFFFF_FFFF);
      $display("test stamping done");
      port_read(1'b1, 1'b1, w);
      cmp_word(w, RD_REFUSED, 32'hFFFF_FFFF);
      port_write();
      cmp_bit(locked, 1'b0);
      for (int k = 0; k < 4; k++)
      begin
         ctrl.profiling_enable    = (k == 2);
         ctrl.trace_source_select = (k != 3);
         port_read(k != 0, k != 1, w);
         cmp_word(w, RD_REFUSED, 32'hFFFF_FFFF);
      end
      ctrl.profiling_enable    = 1'b0;
      ctrl.trace_source_select = 1'b1;
      port_write();
      stall = 4'h5;
      check_line(32'h0656_789A, 32'h0000_1234, '1, '1);
      stall = 4'h0;
      check_line(32'h06AB_CDEF, 32'h0004_4321, '1, '1);
      check_line(32'h0E12_3456, 32'h0009_0000, '1, '1);
      check_line(32'h0712_3456, 32'hFFFF_0000, '1, '1);
      check_line(32'h0656_789A, 32'h0000_1234, '1, '1);
      cmp_word({25'h0, line_count}, 32'h0000_0004, 32'hFFFF_FFFF);
      port_read(1'b1, 1'b1, w);
      port_write();
      check_line(32'h0656_789A, 32'h0000_1234, '1, '1);
      $display("test readout done");
      @(negedge ref_clk_in);
      rst_n_in = 1'b0;
      repeat (2) @(negedge ref_clk_in);
      rst_n_in = 1'b1;
      cmp_word({25'h0, line_count}, 32'h0000_0004, 32'hFFFF_FFFF);
      port_read(1'b1, 1'b1, w);
      cmp_word(w, RD_REFUSED, 32'hFFFF_FFFF);
      port_write();
      check_line(32'h0656_789A, 32'h0000_1234, '1, '1);
      $display("test reset done");
      ctrl.comp_d_seq_select = 1'b1;
      pulse_entry(64'h0, 1'b1);
      repeat (2)
      begin
         seen = seen | comp_seq;
         @(negedge ref_clk_in);
      end
      cmp_bit(seen, 1'b1);
      ctrl.mode      = TBSR_PURE_PC;
      ctrl.mid_align = 1'b1;
      ctrl.armed     = 1'b1;
      pc_step(24'h12_3400, 1'b0);
      pc_step(24'h12_3455, 1'b0);
      pc_step(24'h12_3466, 1'b1);
      pc_step(24'h12_3477, 1'b0);
      pulse_entry(64'h0000_1234_0056_789A, 1'b0);
      pulse_entry(64'h0, 1'b1);
      ctrl.armed = 1'b0;
      @(negedge ref_clk_in);
      cmp_word({25'h0, line_count}, 32'h0000_0002, 32'hFFFF_FFFF);
      port_write();
      check_line(32'h5512_3400, 32'hF112_3466, '1, '1);
      check_line(32'h0012_3477, 32'h3100_0000, '1, '1);
      $display("test sequencer and compressed mode done");
      give_verdict();
   end
endmodule // trace_buffer_timestamp_enable_readout_test
`default_nettype wire
